//--- src/lcsm_cfg.svh
// Constants for the lamp controller two-wire serial slave and its master.
// Assumes a 10 MHz ref_clk and a serial clock far slower than it.
`ifndef LCSM_CFG_SVH
`define LCSM_CFG_SVH
`define LCSM_SLAVE_ADDR   7'h2d
`define LCSM_BRIGHT_RST   5'h17
`define LCSM_SHDN_RST     3'h1
`define LCSM_FAULT_RST    2'h3
`define LCSM_CMD_RST      8'h80
`define LCSM_SCL_HALF_NS  400
`define LCSM_CLK_NS       100
`define LCSM_SCL_HALF_CYC (`LCSM_SCL_HALF_NS / `LCSM_CLK_NS)
// Identification values below are arbitrary
`define LCSM_CHIP_ID      8'h3c
`define LCSM_MFG_ID       8'h21
`define LCSM_CHIP_REV     8'h00
`endif

//--- src/lcsm_pkg.sv
// Types shared by both ends of the lamp controller serial link.
// Assumes lcsm_cfg.svh supplies the numeric constants.
package lcsm_pkg;
  typedef enum logic [6:0] {
    LCSM_S_IDLE = 7'h01,
    LCSM_S_ADDR = 7'h02,
    LCSM_S_CMD  = 7'h04,
    LCSM_S_WDAT = 7'h08,
    LCSM_S_RDAT = 7'h10,
    LCSM_S_ACK  = 7'h20,
    LCSM_S_SKIP = 7'h40
  } lcsm_slv_state_t;
  typedef enum logic [2:0] {
    LCSM_OP_WRITE   = 3'h1,
    LCSM_OP_READ    = 3'h2,
    LCSM_OP_SEND    = 3'h3,
    LCSM_OP_RECEIVE = 3'h4
  } lcsm_op_t;
endpackage

//--- src/lcsm_if.sv
// Two-wire link between the lamp controller slave and its master.
// Assumes both ends use output enables; the wire level is the wired AND.
`timescale 1ns/1ps
interface lcsm_if;
  logic mst_sda_oe;
  logic mst_scl_oe;
  logic slv_sda_oe;
  logic ref_or_serial_data_pin;
  logic ctl_or_serial_clock_pin;
  assign ref_or_serial_data_pin  = ~(mst_sda_oe | slv_sda_oe);
  assign ctl_or_serial_clock_pin = ~mst_scl_oe;
  modport slave (
    input  ref_or_serial_data_pin,
    input  ctl_or_serial_clock_pin,
    output slv_sda_oe
  );
  modport master (
    input  ref_or_serial_data_pin,
    input  ctl_or_serial_clock_pin,
    output mst_sda_oe,
    output mst_scl_oe
  );
endinterface

//--- src/lcsm_slave.sv
// Device end: serial slave holding brightness, shutdown select and fault flags.
// Assumes ref_clk oversamples the serial clock at least eight times.
`timescale 1ns/1ps
`include "lcsm_cfg.svh"
module lcsm_slave (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic mode_strap,
  input  wire logic [1:0] fault_in,
  lcsm_if.slave     bus,
  output logic [4:0] brightness_code,
  output logic [2:0] shutdown_select,
  output logic [1:0] fault_flags,
  output logic       serial_mode
);
  // ==================================================================
  // Synchronisers
  logic [1:0] sda_sync_reg;
  logic [1:0] scl_sync_reg;
  logic       sda_d_reg;
  logic       scl_d_reg;
  logic [1:0] mode_sync_reg;
  logic [1:0] flt_sync_reg;
  logic [1:0] flt_mid_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_sync_reg  <= 2'h3;
      scl_sync_reg  <= 2'h3;
      sda_d_reg     <= 1'b1;
      scl_d_reg     <= 1'b1;
      mode_sync_reg <= 2'h0;
      flt_mid_reg   <= 2'h3;
      flt_sync_reg  <= 2'h3;
    end else begin
      sda_sync_reg  <= {sda_sync_reg[0], bus.ref_or_serial_data_pin};
      scl_sync_reg  <= {scl_sync_reg[0], bus.ctl_or_serial_clock_pin};
      sda_d_reg     <= sda_sync_reg[1];
      scl_d_reg     <= scl_sync_reg[1];
      mode_sync_reg <= {mode_sync_reg[0], mode_strap};
      flt_mid_reg   <= fault_in;
      flt_sync_reg  <= flt_mid_reg;
    end
  end
  wire sda   = sda_sync_reg[1];
  wire scl   = scl_sync_reg[1];
  wire smode = mode_sync_reg[1];
  wire start_ev = smode & scl & scl_d_reg & sda_d_reg & ~sda;
  wire stop_ev  = smode & scl & scl_d_reg & ~sda_d_reg & sda;
  wire scl_rise = smode & scl & ~scl_d_reg;
  wire scl_fall = smode & ~scl & scl_d_reg;
  // ==================================================================
  // Protocol engine
  lcsm_pkg::lcsm_slv_state_t state_reg;
  lcsm_pkg::lcsm_slv_state_t after_ack_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] cmd_reg;
  logic [7:0] wdat_reg;
  logic       wpend_reg;
  logic       ack_bit_reg;
  logic       sda_oe_reg;
  logic       tx_reg;
  logic       rd_bit_reg;
  logic [4:0] bright_reg;
  logic [2:0] shdn_reg;
  logic [1:0] fault_reg;
  wire addr_match = (shift_reg[7:1] == `LCSM_SLAVE_ADDR);
  wire [7:0] rd_data =
    cmd_reg[7]                    ? (cmd_reg[6] ? (cmd_reg[0] ? `LCSM_CHIP_ID : `LCSM_MFG_ID)
                                                : {bright_reg, 1'b1, fault_reg}) :
    (cmd_reg[1:0] == 2'h1)        ? {3'h0, bright_reg} :
    (cmd_reg[1:0] == 2'h2)        ? {fault_reg, 3'h7, shdn_reg} :
    (cmd_reg[1:0] == 2'h3)        ? `LCSM_CHIP_ID : `LCSM_CHIP_REV;
  wire bit_done = (bit_cnt_reg == 4'h8);
  wire commit   = (start_ev | stop_ev) & wpend_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= lcsm_pkg::LCSM_S_IDLE;
      after_ack_reg <= lcsm_pkg::LCSM_S_IDLE;
      shift_reg     <= 8'h00;
      bit_cnt_reg   <= 4'h0;
      cmd_reg       <= `LCSM_CMD_RST;
      wdat_reg      <= 8'h00;
      wpend_reg     <= 1'b0;
      ack_bit_reg   <= 1'b0;
      sda_oe_reg    <= 1'b0;
      tx_reg        <= 1'b0;
      rd_bit_reg    <= 1'b0;
    end else if (start_ev | stop_ev) begin
      wpend_reg   <= 1'b0;
      sda_oe_reg  <= 1'b0;
      tx_reg      <= 1'b0;
      bit_cnt_reg <= 4'h0;
      state_reg   <= start_ev ? lcsm_pkg::LCSM_S_ADDR : lcsm_pkg::LCSM_S_IDLE;
    end else begin
      case (state_reg)
        lcsm_pkg::LCSM_S_ADDR, lcsm_pkg::LCSM_S_CMD, lcsm_pkg::LCSM_S_WDAT: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_done) begin
            bit_cnt_reg <= 4'h0;
            state_reg   <= lcsm_pkg::LCSM_S_ACK;
            sda_oe_reg  <= 1'b1;
            if (state_reg == lcsm_pkg::LCSM_S_ADDR) begin
              if (!addr_match) begin
                sda_oe_reg <= 1'b0;
                state_reg  <= lcsm_pkg::LCSM_S_SKIP;
              end else begin
                after_ack_reg <= shift_reg[0] ? lcsm_pkg::LCSM_S_RDAT : lcsm_pkg::LCSM_S_CMD;
              end
            end else if (state_reg == lcsm_pkg::LCSM_S_CMD) begin
              cmd_reg       <= shift_reg;
              after_ack_reg <= lcsm_pkg::LCSM_S_WDAT;
            end else begin
              wdat_reg      <= shift_reg;
              wpend_reg     <= 1'b1;
              after_ack_reg <= lcsm_pkg::LCSM_S_SKIP;
            end
          end
        end
        lcsm_pkg::LCSM_S_ACK: begin
          if (scl_fall) begin
            state_reg  <= after_ack_reg;
            sda_oe_reg <= 1'b0;
            if (after_ack_reg == lcsm_pkg::LCSM_S_RDAT) begin
              shift_reg  <= rd_data;
              tx_reg     <= 1'b1;
              sda_oe_reg <= ~rd_data[7];
            end
          end
        end
        lcsm_pkg::LCSM_S_RDAT: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            rd_bit_reg  <= sda;
          end else if (scl_fall) begin
            if (bit_done) begin
              tx_reg     <= 1'b0;
              sda_oe_reg <= 1'b0;
            end else if (bit_cnt_reg == 4'h9) begin
              bit_cnt_reg <= 4'h0;
              state_reg   <= lcsm_pkg::LCSM_S_SKIP;
            end else begin
              shift_reg  <= {shift_reg[6:0], 1'b0};
              sda_oe_reg <= ~shift_reg[6];
            end
          end
        end
        lcsm_pkg::LCSM_S_SKIP: begin
          sda_oe_reg <= 1'b0;
        end
        lcsm_pkg::LCSM_S_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        default: begin
          state_reg  <= lcsm_pkg::LCSM_S_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end
  // ==================================================================
  // Registers
  wire wr_bright = commit & ((cmd_reg[7:6] == 2'h2) | (~cmd_reg[7] & (cmd_reg[1:0] == 2'h1)));
  wire wr_shdn   = commit & ~cmd_reg[7] & (cmd_reg[1:0] == 2'h2);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bright_reg      <= `LCSM_BRIGHT_RST;
      shdn_reg        <= `LCSM_SHDN_RST;
      fault_reg       <= `LCSM_FAULT_RST;
      brightness_code <= `LCSM_BRIGHT_RST;
      shutdown_select <= `LCSM_SHDN_RST;
      fault_flags     <= `LCSM_FAULT_RST;
      serial_mode     <= 1'b0;
    end else begin
      if (wr_bright) begin
        bright_reg <= cmd_reg[7] ? wdat_reg[7:3] : wdat_reg[4:0];
      end
      if (wr_shdn) begin
        shdn_reg <= wdat_reg[2:0];
      end
      fault_reg       <= flt_sync_reg;
      brightness_code <= bright_reg;
      shutdown_select <= shdn_reg;
      fault_flags     <= fault_reg;
      serial_mode     <= smode;
    end
  end
  assign bus.slv_sda_oe = sda_oe_reg;
endmodule

//--- src/lcsm_master.sv
// Host end: issues one byte-wide transfer per request on the two-wire link.
// Assumes the slave never stretches the clock.
`timescale 1ns/1ps
`include "lcsm_cfg.svh"
module lcsm_master (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic req,
  input  wire logic [2:0] op,
  input  wire logic [7:0] cmd,
  input  wire logic [7:0] wdata,
  lcsm_if.master    bus,
  output logic       busy,
  output logic       done,
  output logic       nack,
  output logic [7:0] rdata
);
  // ==================================================================
  // Bit sequencer: a list of symbols, each four quarter phases
  logic [1:0] sda_sync_reg;
  logic [2:0] op_reg;
  logic [7:0] cmd_reg;
  logic [7:0] wdat_reg;
  logic [5:0] sym_reg;
  logic [1:0] ph_reg;
  logic [7:0] div_reg;
  logic [7:0] rsh_reg;
  logic       sda_oe_reg;
  logic       scl_oe_reg;
  wire sda_in = sda_sync_reg[1];
  wire tick   = (div_reg == 8'(`LCSM_SCL_HALF_CYC / 2 - 1));
  // Symbols: 0 start, 1-9 addr byte, 10-18 cmd, 19-27 write data (28 stop), or 19 restart, 20-28 read addr, 29-37 read, 38 stop; send stops at 19
  wire is_read  = (op_reg == lcsm_pkg::LCSM_OP_READ);
  wire is_recv  = (op_reg == lcsm_pkg::LCSM_OP_RECEIVE);
  wire is_send  = (op_reg == lcsm_pkg::LCSM_OP_SEND);
  wire [5:0] first_sym = is_recv ? 6'd19 : 6'd0;
  wire [5:0] last_sym  = is_send ? 6'd19 : (is_read | is_recv) ? 6'd38 : 6'd28;
  wire [7:0] addr_w = {`LCSM_SLAVE_ADDR, 1'b0};
  wire [7:0] addr_r = {`LCSM_SLAVE_ADDR, 1'b1};
  wire [7:0] cur_byte =
    (sym_reg <= 6'd9)  ? addr_w :
    (sym_reg <= 6'd18) ? cmd_reg :
    (sym_reg <= 6'd28) ? (is_write_data() ? wdat_reg : 8'hff) : addr_r;
  function automatic logic is_write_data();
    is_write_data = (op_reg == lcsm_pkg::LCSM_OP_WRITE);
  endfunction
  // Symbol 19 is restart (read types) or first data bit (write), 20-28 read address
  wire restart_sym = (sym_reg == 6'd19) & (is_read | is_recv);
  wire stop_sym    = (sym_reg == last_sym);
  wire start_sym   = (sym_reg == first_sym);
  wire [5:0] bpos  = restart_sym ? 6'd0 : (sym_reg > 6'd19 && !is_write_data()) ? sym_reg - 6'd20 : sym_reg - 6'd1;
  wire [3:0] bit_i = 4'(bpos % 6'd9);
  wire [7:0] tx_byte = (is_write_data() | is_send | (sym_reg <= 6'd18)) ? cur_byte : addr_r;
  wire is_ack_slot = (bit_i == 4'h8);
  wire host_rx     = (!is_write_data() && !is_send && sym_reg > 6'd28 && bit_i != 4'h8 && !stop_sym);
  wire ack_sample  = is_ack_slot & !host_rx & !(sym_reg > 6'd28 && !is_write_data() && !is_send);
  wire want_low    = start_sym ? (ph_reg != 2'h0) :
                     restart_sym ? (ph_reg == 2'h3) :
                     stop_sym ? (ph_reg != 2'h3) :
                     (host_rx | is_ack_slot) ? ((sym_reg > 6'd28) & is_ack_slot & 1'b0) :
                     ~tx_byte[3'(7 - bit_i)];
  wire scl_low     = (ph_reg == 2'h0) | ((ph_reg == 2'h3) & !stop_sym & !restart_sym & !start_sym);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_sync_reg <= 2'h3;
      op_reg       <= 3'h0;
      cmd_reg      <= 8'h00;
      wdat_reg     <= 8'h00;
      sym_reg      <= 6'd0;
      ph_reg       <= 2'h0;
      div_reg      <= 8'h00;
      rsh_reg      <= 8'h00;
      sda_oe_reg   <= 1'b0;
      scl_oe_reg   <= 1'b0;
      busy         <= 1'b0;
      done         <= 1'b0;
      nack         <= 1'b0;
      rdata        <= 8'h00;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], bus.ref_or_serial_data_pin};
      done         <= 1'b0;
      if (!busy) begin
        if (req) begin
          busy     <= 1'b1;
          op_reg   <= op;
          cmd_reg  <= cmd;
          wdat_reg <= wdata;
          sym_reg  <= (op == lcsm_pkg::LCSM_OP_RECEIVE) ? 6'd19 : 6'd0;
          ph_reg   <= 2'h0;
          div_reg  <= 8'h00;
          nack     <= 1'b0;
        end
      end else begin
        div_reg <= tick ? 8'h00 : div_reg + 8'h01;
        if (tick) begin
          sda_oe_reg <= want_low;
          scl_oe_reg <= scl_low & !start_sym;
          if (ph_reg == 2'h2) begin
            if (ack_sample && sda_in) begin
              nack <= 1'b1;
            end
            if (host_rx) begin
              rsh_reg <= {rsh_reg[6:0], sda_in};
            end
          end
          ph_reg <= ph_reg + 2'h1;
          if (ph_reg == 2'h3) begin
            if (stop_sym) begin
              busy       <= 1'b0;
              done       <= 1'b1;
              sda_oe_reg <= 1'b0;
              scl_oe_reg <= 1'b0;
              rdata      <= rsh_reg;
            end else begin
              sym_reg <= sym_reg + 6'd1;
            end
          end
        end
      end
    end
  end
  assign bus.mst_sda_oe = sda_oe_reg;
  assign bus.mst_scl_oe = scl_oe_reg;
endmodule

//--- testbench/lcsm_link_chk.sv
// Checker watching the two-wire link between master and slave ends.
// Assumes pins are levels launched from ref_clk and the slave strap is high.
`timescale 1ns/1ps
module lcsm_link_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic mst_sda_oe,
  input wire logic mst_scl_oe,
  input wire logic slv_sda_oe,
  input wire logic ref_or_serial_data_pin,
  input wire logic ctl_or_serial_clock_pin
);
  // ====================
  // Link monitor
  logic       scl_q_reg, sda_q_reg, in_frame_reg;
  logic [3:0] bit_reg;
  logic [1:0] byte_reg;
  logic [7:0] sh_reg, adr_reg;
  wire        sda      = ref_or_serial_data_pin;
  wire        scl      = ctl_or_serial_clock_pin;
  wire        start_w  = scl & scl_q_reg & sda_q_reg & ~sda;
  wire        stop_w   = scl & scl_q_reg & ~sda_q_reg & sda;
  wire        rise_w   = scl & ~scl_q_reg;
  wire        ack_w    = rise_w & (bit_reg == 4'h8);
  wire        adr_ok_w = (adr_reg[7:1] == 7'h2d);
  wire        rd_w     = adr_ok_w & adr_reg[0] & (byte_reg != 2'h0);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_q_reg, sda_q_reg, in_frame_reg} <= 3'h6;
      {bit_reg, byte_reg, sh_reg, adr_reg} <= 22'h0;
    end else begin
      scl_q_reg <= scl;
      sda_q_reg <= sda;
      if (start_w) begin
        {in_frame_reg, bit_reg, byte_reg} <= 7'h40;
      end else if (stop_w) begin
        in_frame_reg <= 1'b0;
      end else if (ack_w) begin
        bit_reg  <= 4'h0;
        byte_reg <= byte_reg + {1'b0, byte_reg != 2'h3};
        if (byte_reg == 2'h0) adr_reg <= sh_reg;
      end else if (rise_w) begin
        bit_reg <= bit_reg + 4'h1;
        sh_reg  <= {sh_reg[6:0], sda};
      end
    end
  end
  // ====================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_ADDR_ACK: assert property (ack_w && byte_reg == 2'h0 |-> sda == (sh_reg[7:1] != 7'h2d))
    else $error("address acknowledge wrong");
  AST_WR_ACK: assert property (ack_w && byte_reg != 2'h0 && adr_ok_w && !adr_reg[0] |-> !sda)
    else $error("write byte not acknowledged");
  AST_RD_NACK: assert property (ack_w && rd_w |-> !slv_sda_oe && sda)
    else $error("read byte not closed by not-acknowledge");
  AST_MST_SLOT: assert property (rise_w && !ack_w && !rd_w |-> !slv_sda_oe)
    else $error("slave drives data in a master slot");
  AST_SLV_EDGE: assert property ($changed(slv_sda_oe) |-> !scl)
    else $error("slave data changed while clock high");
  AST_IDLE_CLK: assert property (!in_frame_reg |-> scl)
    else $error("serial clock low outside a frame");
  AST_IDLE_SLV: assert property (!in_frame_reg |-> !slv_sda_oe)
    else $error("slave drives data outside a frame");
  AST_HIGH_TIME: assert property (rise_w |-> scl [*4])
    else $error("serial clock high phase too short");
endmodule

//--- testbench/test_lamp_ctrl_smbus_slave.sv
// Bench for both link ends plus a bit-level driver against a second slave.
// Assumes a 10 MHz ref_clk and the designer's serial timing.
`timescale 1ns/1ps
module test_lamp_ctrl_smbus_slave;
  logic       ref_clk = 0, rst_n = 0, req = 0, strap2 = 0, m_sda = 0, m_scl = 0, a;
  logic [2:0] op = 3'h1;
  logic [7:0] cmd = 8'h0, wdata = 8'h0;
  logic [1:0] fault_in = 2'h3;
  wire        busy, done, nack, sm1, sm2;
  wire  [7:0] rdata;
  wire  [4:0] br1, br2;
  wire  [2:0] sh1;
  wire  [1:0] fl1;
  int         err_count = 0, num_checks = 0, cyc = 0;
  lcsm_if bus();
  lcsm_if bus2();
  assign bus2.mst_sda_oe = m_sda;
  assign bus2.mst_scl_oe = m_scl;
  lcsm_master i_lcsm_master (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .op(op), .cmd(cmd),
    .wdata(wdata), .bus(bus.master), .busy(busy), .done(done), .nack(nack), .rdata(rdata));
  lcsm_slave i_lcsm_slave (.ref_clk(ref_clk), .rst_n(rst_n), .mode_strap(1'b1), .fault_in(fault_in),
    .bus(bus.slave), .brightness_code(br1), .shutdown_select(sh1), .fault_flags(fl1), .serial_mode(sm1));
  lcsm_slave i_lcsm_slave_b (.ref_clk(ref_clk), .rst_n(rst_n), .mode_strap(strap2), .fault_in(2'h3),
    .bus(bus2.slave), .brightness_code(br2), .shutdown_select(), .fault_flags(), .serial_mode(sm2));
  lcsm_link_chk i_lcsm_link_chk (.ref_clk(ref_clk), .rst_n(rst_n), .mst_sda_oe(bus.mst_sda_oe),
    .mst_scl_oe(bus.mst_scl_oe), .slv_sda_oe(bus.slv_sda_oe),
    .ref_or_serial_data_pin(bus.ref_or_serial_data_pin),
    .ctl_or_serial_clock_pin(bus.ctl_or_serial_clock_pin));
  // ====================
  // Clock, timeout, report
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ====================
  // Transfer through the master end
  task xfer(input logic [2:0] o, input logic [7:0] c, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    {op, cmd, wdata, req} = {o, c, d, 1'b1};
    @(negedge ref_clk);
    req = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (4) @(negedge ref_clk);
    chk({7'h0, nack}, 8'h00);
  endtask
  // ====================
  // Bit-level driver on the second link
  task w2;
    repeat (2) @(negedge ref_clk);
  endtask
  task bb_bit(input logic b, output logic s);
    m_sda = ~b; w2(); m_scl = 0; w2();
    s = bus2.ref_or_serial_data_pin; w2(); m_scl = 1; w2();
  endtask
  task bb_byte(input logic [7:0] v, input int n, output logic s);
    for (int i = 7; i > 7 - n; i--) bb_bit(v[i], s);
    if (n == 8) bb_bit(1'b1, s);
  endtask
  task bb_cond(input logic stop);
    m_sda = stop; w2(); m_scl = 0; w2(); m_sda = ~stop; w2(); m_scl = ~stop; w2();
  endtask
  // ====================
  // Main sequence
  initial begin
    repeat (2) @(negedge ref_clk);
    chk({3'h0, br1}, 8'h17);
    chk({5'h0, sh1}, 8'h01);
    chk({6'h0, fl1}, 8'h03);
    chk({7'h0, sm1}, 8'h00);
    rst_n = 1;
    repeat (3) @(negedge ref_clk);
    chk({7'h0, sm1}, 8'h01);
    xfer(lcsm_pkg::LCSM_OP_RECEIVE, 8'h00, 8'h00);
    chk(rdata, 8'hbf);
    xfer(lcsm_pkg::LCSM_OP_WRITE, 8'h01, 8'h0a);
    chk({3'h0, br1}, 8'h0a);
    xfer(lcsm_pkg::LCSM_OP_READ, 8'h01, 8'h00);
    chk(rdata, 8'h0a);
    xfer(lcsm_pkg::LCSM_OP_WRITE, 8'h02, 8'h00);
    chk({5'h0, sh1}, 8'h00);
    xfer(lcsm_pkg::LCSM_OP_WRITE, 8'h80, 8'hf8);
    chk({3'h0, br1}, 8'h1f);
    fault_in = 2'h1;
    xfer(lcsm_pkg::LCSM_OP_READ, 8'h02, 8'h00);
    chk(rdata, 8'h78);
    chk({6'h0, fl1}, 8'h01);
    xfer(lcsm_pkg::LCSM_OP_SEND, 8'h01, 8'h00);
    xfer(lcsm_pkg::LCSM_OP_RECEIVE, 8'h00, 8'h00);
    chk(rdata, 8'h1f);
    bb_cond(0); bb_byte(8'h5a, 8, a); bb_cond(1);
    chk({7'h0, a}, 8'h01);
    chk({7'h0, sm2}, 8'h00);
    strap2 = 1;
    repeat (3) @(negedge ref_clk);
    chk({7'h0, sm2}, 8'h01);
    bb_cond(0); bb_byte(8'h5c, 8, a); bb_cond(1);
    chk({7'h0, a}, 8'h01);
    bb_cond(0); bb_byte(8'h5a, 8, a);
    chk({7'h0, a}, 8'h00);
    bb_byte(8'h01, 8, a); bb_byte(8'h09, 4, a); bb_cond(1); w2();
    chk({3'h0, br2}, 8'h17);
    bb_cond(0); bb_byte(8'h5a, 8, a); bb_byte(8'h01, 8, a); bb_byte(8'h09, 8, a);
    chk({7'h0, a}, 8'h00);
    chk({3'h0, br2}, 8'h17);
    bb_cond(0); w2(); w2();
    chk({3'h0, br2}, 8'h09);
    bb_cond(1);
    wrap_up();
  end
endmodule
